/* design/pss_defines.svh */
// Constants for the pipelined synchronous memory port
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// Address width: 256K words
`define PSS_ADDR_W 18
// Data width: one 32-bit word
`define PSS_DATA_W 32
// Byte lanes per word
`define PSS_LANES 4
// Burst counter width
`define PSS_BURST_W 2
// Words in the array
`define PSS_DEPTH 262144
// Reset value of the burst counter
`define PSS_BURST_RST 2'h0
// Burst order select levels
`define PSS_ORDER_LINEAR 1'h0
`define PSS_ORDER_INTERLEAVED 1'h1
// All lanes enabled; no lanes enabled
`define PSS_ALL_LANES 4'hF
`define PSS_NO_LANES 4'h0

`endif

/* design/pss_pkg.sv */
// Types shared by the memory port modules
`include "pss_defines.svh"

package pss_pkg;

    // Access state of the port
    typedef enum logic [2:0]
    {
        PSS_IDLE  = 3'h1,
        PSS_READ  = 3'h2,
        PSS_WRITE = 3'h4
    } pss_state_t;

    typedef logic [`PSS_ADDR_W-1:0] pss_addr_t;
    typedef logic [`PSS_DATA_W-1:0] pss_data_t;
    typedef logic [`PSS_LANES-1:0] pss_lanes_t;

endpackage

/* design/pss_mem_if.sv */
// Interface between the port logic and its storage array
`timescale 1ns/10ps
`default_nettype none

interface pss_mem_if;
    // Word address
    pss_pkg::pss_addr_t addr;
    // Read strobe
    logic rd;
    // Per-lane write enables
    pss_pkg::pss_lanes_t wr_lanes;
    // Write data
    pss_pkg::pss_data_t wdata;
    // Registered read data
    pss_pkg::pss_data_t rdata;

    // Port logic side
    modport ctrl
    (
        output addr,
        output rd,
        output wr_lanes,
        output wdata,
        input rdata
    );

    // Array side
    modport mem
    (
        input addr,
        input rd,
        input wr_lanes,
        input wdata,
        output rdata
    );
endinterface

`default_nettype wire

/* design/pss_array.sv */
// Storage array with byte-lane writes and registered read data
`timescale 1ns/10ps
`default_nettype none

// Width and depth constants
`include "pss_defines.svh"

module pss_array
(
    input wire logic clk_sys,
    pss_mem_if.mem mem
);

    // ==========================================
    // Storage
    // ==========================================
    // One word per location
    logic [`PSS_DATA_W-1:0] store [0:`PSS_DEPTH-1];

    // Byte-lane write, each lane on its own enable
    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < `PSS_LANES; i++)
        begin
            if (mem.wr_lanes[i])
                store[mem.addr][i*8 +: 8] <= mem.wdata[i*8 +: 8];
        end
    end

    // Read word lands in a register
    always_ff @(posedge clk_sys)
    begin
        if (mem.rd)
            mem.rdata <= store[mem.addr];
    end

endmodule

`default_nettype wire

/* design/pss_port.sv */
// Synchronous pipelined memory port: address load, burst, writes, reads
// Notes on behaviour
// [R1] Sample all synchronous inputs on rising clock only
// [R2] Registered inputs and registered read outputs
// [R3] Load address, selects only on a strobe
// [R4] Burst addresses advance only on advance input
// [R5] Two-bit burst counter within aligned four
// [R6] Interleaved or linear order chosen by input
// [R7] 256K by 32 words, shared data bus
// [R8] Burst timing three clocks then one each; the two input flops add two clocks before the first word
// [R9] Register write address, data, controls; self-timed
// [R10] Write one to four selected bytes
// [R11] Global write low writes all bytes
// [R12] Output enable and sleep act asynchronously
// [R13] Both strobes active: processor strobe wins
// [R14] Byte write needs enable plus byte selects
// [R15] First read clock after deselect: outputs off
// [R16] Inactive selects at load: deselect, bus off
// [R17] Controller drives bus only during writes
`timescale 1ns/10ps
`default_nettype none

// Order levels, lane masks and counter constants
`include "pss_defines.svh"

module pss_port
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [17:0] addr,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [3:0] byte_select_n,
    input wire logic chip_sel_pipe_n,
    input wire logic chip_sel_depth_hi,
    input wire logic chip_sel_depth_n,
    input wire logic burst_order,
    input wire logic out_enable_n,
    input wire logic sleep_request,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic data_oe
);

    // ==========================================
    // Input synchronisers (pins leave another domain)
    // ==========================================
    // First stage of every synchronous pin
    logic [17:0] addr_s1;
    logic [9:0] ctl_s1;
    logic [3:0] bsel_s1;
    logic [31:0] din_s1;
    // Second stage: the registered inputs the logic reads
    logic [17:0] addr_r;
    logic [9:0] ctl_r;
    logic [3:0] bsel_r;
    logic [31:0] din_r;

    // Two flops on each synchronous pin; the second is the input register [R1] [R2]
    always_ff @(posedge clk_sys)
    begin
        addr_s1 <= addr;
        ctl_s1 <= {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, global_write_n,
                   byte_write_enable_n, chip_sel_pipe_n, chip_sel_depth_hi, chip_sel_depth_n,
                   burst_order, sleep_request};
        bsel_s1 <= byte_select_n;
        din_s1 <= data_in;
        addr_r <= addr_s1;
        ctl_r <= ctl_s1;
        bsel_r <= bsel_s1;
        din_r <= din_s1;
    end

    // ==========================================
    // Decoded controls
    // ==========================================
    // Named fields of the registered control word
    wire proc_stb_n_r = ctl_r[9];
    wire ctrl_stb_n_r = ctl_r[8];
    wire advance_n_r = ctl_r[7];
    wire global_wr_n_r = ctl_r[6];
    wire byte_wr_en_n_r = ctl_r[5];
    wire cs_pipe_n_r = ctl_r[4];
    wire cs_hi_r = ctl_r[3];
    wire cs_depth_n_r = ctl_r[2];
    wire order_r = ctl_r[1];
    // Synchronised sleep; gates clocked array access only
    wire sleep_r = ctl_r[0];

    // Processor strobe ignored while pipe select is high
    wire proc_load = !proc_stb_n_r && !cs_pipe_n_r;
    // Controller strobe only counts when processor strobe is absent [R13]
    wire ctrl_load = !ctrl_stb_n_r && proc_stb_n_r;
    // Address load event [R3]
    wire load = proc_load || ctrl_load;
    // All three selects active
    wire selected = !cs_pipe_n_r && cs_hi_r && !cs_depth_n_r;
    // Lanes requested by the write controls [R10] [R11] [R14]
    wire [3:0] lanes_req = write_lanes(global_wr_n_r, byte_wr_en_n_r, bsel_r);
    // Any write intended this cycle
    wire wr_req = lanes_req != `PSS_NO_LANES;
    // Selected processor-strobe loads always start as reads
    wire load_write = ctrl_load && wr_req;

    // Lane decode: global write overrides, else enable plus selects
    function automatic logic [3:0] write_lanes(input logic glob_n, input logic lane_en_n, input logic [3:0] bs_n);
        if (!glob_n)
            write_lanes = `PSS_ALL_LANES;
        else if (!lane_en_n)
            write_lanes = ~bs_n;
        else
            write_lanes = `PSS_NO_LANES;
    endfunction

    // Burst address step for either order [R5] [R6]
    function automatic logic [1:0] burst_addr(input logic [1:0] base, input logic [1:0] cnt, input logic ord);
        if (ord == `PSS_ORDER_INTERLEAVED)
            burst_addr = base ^ cnt;
        else
            burst_addr = base + cnt;
    endfunction

    // ==========================================
    // Address register and burst counter
    // ==========================================
    pss_pkg::pss_state_t state;
    pss_pkg::pss_state_t next_state;
    // Loaded upper address
    logic [15:0] addr_hi;
    // Loaded low address bits
    logic [1:0] addr_base;
    // Burst step count
    logic [1:0] burst_cnt;
    // Loaded order
    logic order_q;
    // Output word may drive: valid, not first after deselect, not in write state
    logic active;
    // Read was issued to the array last cycle
    logic rd_issued;
    // Data output register stage is valid
    logic out_valid;
    // Read launched straight from the deselected state
    logic from_desel;
    // Deselect flag, one cycle delayed with the pipe
    logic from_desel_d;
    // Deselect flag, lined up with the output register stage
    logic from_desel_dd;
    // Write lanes held one clock to meet the loaded address
    logic [3:0] wr_lanes_q;
    // Write data held one clock alongside the lanes
    logic [31:0] wdata_q;

    // Next state on load and during a burst
    always_comb
    begin
        next_state = state;
        if (load)
        begin
            if (!selected)
                next_state = pss_pkg::PSS_IDLE; // [R16]
            else if (load_write)
                next_state = pss_pkg::PSS_WRITE;
            else
                next_state = pss_pkg::PSS_READ;
        end
        else if (state != pss_pkg::PSS_IDLE)
        begin
            case (state)
                pss_pkg::PSS_READ: next_state = wr_req ? pss_pkg::PSS_WRITE : pss_pkg::PSS_READ;
                pss_pkg::PSS_WRITE: next_state = wr_req ? pss_pkg::PSS_WRITE : pss_pkg::PSS_READ;
                default: next_state = pss_pkg::PSS_IDLE;
            endcase
        end
    end

    // State, address and burst counter update
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state <= pss_pkg::PSS_IDLE;
            addr_hi <= 16'h0000;
            addr_base <= `PSS_BURST_RST;
            burst_cnt <= `PSS_BURST_RST;
            order_q <= `PSS_ORDER_LINEAR;
        end
        else
        begin
            state <= next_state;
            if (load)
            begin
                addr_hi <= addr_r[17:2]; // [R3]
                addr_base <= addr_r[1:0];
                burst_cnt <= `PSS_BURST_RST;
                order_q <= order_r;
            end
            else if (!advance_n_r && state != pss_pkg::PSS_IDLE)
                burst_cnt <= burst_cnt + 2'h1; // [R4] [R5]
        end
    end

    // ==========================================
    // Array access
    // ==========================================
    pss_mem_if mif ();

    // Current word address from loaded base and counter [R6] [R7]
    assign mif.addr = {addr_hi, burst_addr(addr_base, burst_cnt, order_q)};
    // Reads run in read state; array read data is registered [R2]
    assign mif.rd = state == pss_pkg::PSS_READ && !sleep_r;
    // Write with registered address, data and lanes; array finishes alone [R9] [R10] [R11]
    assign mif.wr_lanes = (state == pss_pkg::PSS_WRITE && !sleep_r) ? wr_lanes_q : `PSS_NO_LANES;
    assign mif.wdata = wdata_q; // [R9]

    // Write controls and data wait one clock, so that they land together
    // with the address loaded at the same edge; a later cycle's controls
    // would otherwise hit the previous address [R9]
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_lanes_q <= `PSS_NO_LANES;
            wdata_q <= 32'h00000000;
        end
        else
        begin
            // Lanes from global write or enable plus selects [R10] [R11] [R14]
            wr_lanes_q <= lanes_req;
            // Data word taken with its controls [R9]
            wdata_q <= din_r;
        end
    end

    pss_array u_array
    (
        .clk_sys(clk_sys),
        .mem(mif)
    );

    // Output pipeline: array register, then output register [R8]
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rd_issued <= 1'h0;
            out_valid <= 1'h0;
            from_desel <= 1'h0;
            from_desel_d <= 1'h0;
            from_desel_dd <= 1'h0;
            data_out <= 32'h00000000;
        end
        else
        begin
            rd_issued <= mif.rd && !wr_req;
            out_valid <= rd_issued;
            // Read launched by a load out of the idle state [R15]
            from_desel <= load && selected && !load_write && state == pss_pkg::PSS_IDLE;
            from_desel_d <= from_desel;
            // Second delay matches the array and output register stages [R15]
            from_desel_dd <= from_desel_d;
            if (rd_issued)
                data_out <= mif.rdata; // [R2]
        end
    end

    // ==========================================
    // Output drive
    // ==========================================
    // Active flag for the drive term
    assign active = out_valid && !from_desel_dd && state != pss_pkg::PSS_WRITE; // [R15] [R16] [R17]
    // Output enable and sleep gate the drive with no clock [R12]
    assign data_oe = active && !out_enable_n && !sleep_request; // [R12]

endmodule

`default_nettype wire

/* tb/pss_port_monitor.sv */
// Checker of the memory port pins
`timescale 1ns/10ps
`default_nettype none
module pss_port_monitor
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic chip_sel_pipe_n,
    input wire logic chip_sel_depth_hi,
    input wire logic chip_sel_depth_n,
    input wire logic out_enable_n,
    input wire logic sleep_request,
    input wire logic [31:0] data_out,
    input wire logic data_oe
);
    // ==========
    // Load decode
    wire logic sel_on = !chip_sel_pipe_n && chip_sel_depth_hi && !chip_sel_depth_n;
    wire logic rd_ld = !proc_addr_strobe_n && sel_on;
    wire logic ctl_ld = !ctrl_addr_strobe_n && proc_addr_strobe_n;
    wire logic quiet = proc_addr_strobe_n && ctrl_addr_strobe_n && burst_advance_n;
    wire logic go = !out_enable_n && !sleep_request;
    // Clocks since last strobe or advance, held at 7
    logic [2:0] quiet_cnt;
    wire logic [2:0] next_quiet_cnt = quiet ? quiet_cnt + {2'h0, quiet_cnt != 3'h7} : 3'h0;
    always_ff @(posedge clk_sys)
        quiet_cnt <= rst ? 3'h7 : next_quiet_cnt;
    // ==========
    // Pin checks
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_oe_needs_enable:
        assert property (data_oe |-> !out_enable_n) else $error("drive, enable off");
    a_sleep_no_drive:
        assert property (sleep_request |-> !data_oe) else $error("drive in sleep");
    a_oe_after_access:
        assert property (data_oe |-> quiet_cnt < 3'h6) else $error("late drive");
    a_out_after_access:
        assert property ($changed(data_out) |-> quiet_cnt < 3'h6) else $error("stray data");
    a_read_second_word:
        assert property (rd_ld ##1 go && !burst_advance_n ##1 go [*5] |=> data_oe) else $error("no word");
    a_write_no_drive:
        assert property (ctl_ld && sel_on && !global_write_n ##1 quiet [*5] |=> !data_oe) else $error("wr drive");
    a_deselect_bus_off:
        assert property (ctl_ld && !sel_on ##1 quiet [*5] |=> !data_oe) else $error("deselect drive");
    a_first_read_off:
        assert property (ctl_ld && !sel_on ##1 rd_ld |-> ##5 !data_oe) else $error("first word drive");
    c_burst: cover property (data_oe [*3]);
    c_first: cover property (ctl_ld && !sel_on ##1 rd_ld);
    c_write: cover property (ctl_ld && sel_on && !global_write_n ##1 quiet [*5]);
endmodule
bind pss_port pss_port_monitor u_mon (.*);
`default_nettype wire

/* tb/pss_ctrl_model.sv */
// Processor-side model driving the memory port pins
`timescale 1ns/10ps
`default_nettype none
module pss_ctrl_model
(
    input wire logic clk_sys,
    output var logic [17:0] addr,
    output var logic proc_addr_strobe_n,
    output var logic ctrl_addr_strobe_n,
    output var logic burst_advance_n,
    output var logic global_write_n,
    output var logic byte_write_enable_n,
    output var logic [3:0] byte_select_n,
    output var logic chip_sel_pipe_n,
    output var logic chip_sel_depth_hi,
    output var logic chip_sel_depth_n,
    output var logic burst_order,
    output var logic out_enable_n,
    output var logic sleep_request,
    output var logic [31:0] data_in
);
    // ==========
    // Idle bus at time zero
    initial
    begin
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, out_enable_n} = 4'hF;
        {global_write_n, byte_write_enable_n, byte_select_n} = 6'h3F;
        {sleep_request, burst_order, chip_sel_pipe_n, chip_sel_depth_hi, chip_sel_depth_n} = 5'h02;
        {addr, data_in} = 50'h0;
    end
    // Address phase for one clock
    task automatic load(input logic [1:0] stb_n, input logic [4:0] sel, input logic [17:0] a,
        input logic [5:0] wc, input logic [31:0] d);
        @(posedge clk_sys);
        {proc_addr_strobe_n, ctrl_addr_strobe_n} <= stb_n;
        {sleep_request, burst_order, chip_sel_pipe_n, chip_sel_depth_hi, chip_sel_depth_n} <= sel;
        {global_write_n, byte_write_enable_n, byte_select_n} <= wc;
        out_enable_n <= 1'b1;
        burst_advance_n <= 1'b1;
        addr <= a;
        data_in <= d;
    endtask
    // Burst or idle step; released lines and selects toggle
    task automatic step(input logic [1:0] adv_oe);
        @(posedge clk_sys);
        {proc_addr_strobe_n, ctrl_addr_strobe_n} <= 2'h3;
        {global_write_n, byte_write_enable_n, byte_select_n} <= 6'h3F;
        {burst_advance_n, out_enable_n} <= adv_oe;
        {burst_order, chip_sel_pipe_n, chip_sel_depth_hi, chip_sel_depth_n} <=
            ~{burst_order, chip_sel_pipe_n, chip_sel_depth_hi, chip_sel_depth_n};
        addr <= ~addr;
        data_in <= ~data_in;
    endtask
endmodule
`default_nettype wire

/* tb/pipelined_sync_sram_port_test.sv */
// Bench of the memory port
`timescale 1ns/10ps
`default_nettype none
module pipelined_sync_sram_port_test;
    // ==========
    // Pins and counters
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    wire logic [17:0] addr;
    wire logic [31:0] data_in, data_out;
    wire logic [3:0] byte_select_n;
    wire logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, global_write_n;
    wire logic byte_write_enable_n, chip_sel_pipe_n, chip_sel_depth_hi, chip_sel_depth_n;
    wire logic burst_order, out_enable_n, sleep_request, data_oe;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    // Expected words of the top group
    logic [31:0] mem_exp [4];
    // Rows: offset, {global, byte enable, lanes}, data
    typedef struct packed {logic [1:0] off; logic [5:0] wc; logic [31:0] d;} pss_row_t;
    pss_row_t rows [8] = '{'{2'h0, 6'h1F, 32'h11111111}, '{2'h1, 6'h0F, 32'h22222222},
        '{2'h2, 6'h10, 32'h33333333}, '{2'h3, 6'h00, 32'h44444444}, '{2'h1, 6'h2A, 32'hAAAAAAAA},
        '{2'h2, 6'h30, 32'h55555555}, '{2'h3, 6'h27, 32'h77777777}, '{2'h0, 6'h2E, 32'h99999999}};
    pss_ctrl_model u_ctl (.*);
    pss_port u_dut (.*);
    initial
        forever #4 clk_sys = ~clk_sys;
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Burst of four from offset s; words 1 to 3 checked
    task automatic rd(input logic [1:0] s, input logic o, input logic sl, input logic oen);
        logic [1:0] w;
        u_ctl.load(2'h1, {sl, o, 3'h2}, {16'hFFFF, s}, 6'h3F, 32'h0);
        repeat (3) u_ctl.step({1'b0, oen});
        u_ctl.step({1'b1, oen});
        @(posedge clk_sys);
        for (int k = 1; k < 4; k++)
        begin
            @(posedge clk_sys);
            #1;
            w = o ? s ^ k[1:0] : s + k[1:0];
            chk("drive", {31'h0, data_oe}, {31'h0, !sl && !oen});
            if (!sl)
                chk("word", data_out, mem_exp[w]);
        end
    endtask
    // Hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1;
        chk("reset oe", {31'h0, data_oe}, 32'h0);
        chk("reset out", data_out, 32'h0);
        @(posedge clk_sys);
        rst <= 1'b0;
        // Back-to-back controller loads from the row table; all but the 6'h30 row write
        foreach (rows[i])
        begin
            u_ctl.load(2'h2, 5'h02, {16'hFFFF, rows[i].off}, rows[i].wc, rows[i].d);
            for (int b = 0; b < 4; b++)
                if (!rows[i].wc[5] || !rows[i].wc[4] && !rows[i].wc[b])
                    mem_exp[rows[i].off][8*b+:8] = rows[i].d[8*b+:8];
        end
        repeat (6) u_ctl.step(2'h3);
        // Both orders from starts 1 to 3
        for (int o = 0; o < 2; o++)
            for (int s = 1; s < 4; s++)
                rd(s[1:0], o[0], 1'b0, 1'b0);
        rd(2'h1, 1'b0, 1'b1, 1'b0);
        rd(2'h1, 1'b1, 1'b0, 1'b1);
        // Both strobes, then deselected write, then read at once
        u_ctl.load(2'h0, 5'h02, 18'h3FFFC, 6'h00, 32'hDEADBEEF);
        u_ctl.load(2'h2, 5'h06, 18'h3FFFE, 6'h00, 32'hDEADBEEF);
        rd(2'h1, 1'b0, 1'b0, 1'b0);
        u_ctl.load(2'h2, 5'h00, 18'h3FFFF, 6'h00, 32'h0);
        repeat (6) u_ctl.step(2'h3);
        rd(2'h2, 1'b0, 1'b0, 1'b0);
        // Reset in mid burst
        u_ctl.load(2'h1, 5'h02, 18'h3FFFC, 6'h3F, 32'h0);
        repeat (4) u_ctl.step(2'h0);
        rst <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("reset oe", {31'h0, data_oe}, 32'h0);
        chk("reset out", data_out, 32'h0);
        @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule
`default_nettype wire
